// ### logic/port_five.sv
// Five-bit general-purpose port with chip-select, refresh and interrupt sharing
//
// Function
// RL1 - Direction register is eight bits, write-only; reads return all ones.
// RL2 - Reset or hardware standby loads direction register with f0.
// RL3 - Software standby keeps both registers; output pins keep driving.
// RL4 - Output data register is eight-bit read/write, holding pins four to zero.
// RL5 - Reset or hardware standby loads output data register with e0.
// RL6 - Port read returns stored data bit where direction bit is one.
// RL7 - Port read returns sampled pin level where direction bit is zero.
// RL8 - Data bits seven to five ignore writes and always read one.
// RL9 - Direction bits four to one drive chip selects zero to three; bit zero plain output.
// RL10 - Cleared direction bit makes the pin an input with driver off.
// RL11 - Refresh enable puts the refresh strobe on pin zero, overriding direction.
// RL12 - Pins three to zero always feed interrupt requests three to zero.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module port_five (
  input  wire logic                                i_clock,
  input  wire logic                                i_reset,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [31:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Power modes
  input  wire logic                                i_hw_standby,
  input  wire logic                                i_sw_standby,
  // Shared functions from on-chip logic
  input  wire logic                                i_chip_select_zero_n,
  input  wire logic                                i_chip_select_one_n,
  input  wire logic                                i_chip_select_two_n,
  input  wire logic                                i_chip_select_three_n,
  input  wire logic                                i_refresh_strobe_n,
  input  wire logic                                i_refresh_output_enable,
  // Pins
  input  wire logic [port_five_pkg::PIN_COUNT-1:0] i_pin_in,
  output logic      [port_five_pkg::PIN_COUNT-1:0] o_pin_out,
  output logic      [port_five_pkg::PIN_COUNT-1:0] o_pin_oe,
  // Interrupt request levels taken from the pins
  output logic      [port_five_pkg::IRQ_COUNT-1:0] o_interrupt_request_n
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // All eight direction bits are stored although only five steer pins; the
  // reserved data bits are not stored at all and are forced on read.
  // Bus answers are registered so pready, prdata and pslverr leave flops.
  typedef struct packed {
    logic [7:0]                          dir;
    logic [port_five_pkg::PIN_COUNT-1:0] data;
    logic                                ready;
    logic [31:0]                         rdata;
    logic                                slverr;
    logic [port_five_pkg::PIN_COUNT-1:0] pin_out;
    logic [port_five_pkg::PIN_COUNT-1:0] pin_oe;
    logic [port_five_pkg::IRQ_COUNT-1:0] irq_n;
  } port_state_t;

  port_state_t                         st_reg;
  port_state_t                         st_next;
  logic [port_five_pkg::PIN_COUNT-1:0] pin_level;
  logic                                access;
  logic                                hit_dir;
  logic                                hit_data;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Word-aligned address match against a register index
  function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] index);
    addr_hit = (addr == {port_five_pkg::ADDR_PAD, index, port_five_pkg::ADDR_LANE});
  endfunction

  // Port read value: stored bit for outputs, pin level for inputs
  function automatic logic [7:0] port_read(
    input logic [7:0]                          dir,
    input logic [port_five_pkg::PIN_COUNT-1:0] data,
    input logic [port_five_pkg::PIN_COUNT-1:0] level
  );
    logic [port_five_pkg::PIN_COUNT-1:0] low;
    low       = (dir[port_five_pkg::PIN_COUNT-1:0] & data)
              | (~dir[port_five_pkg::PIN_COUNT-1:0] & level);  // see RL6 see RL7
    port_read = {port_five_pkg::DATA_RSVD, low};               // see RL8
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  // Pin levels are asynchronous; only the synchronised copy is read, by
  // the port read path and by the interrupt request outputs alike.
  pin_sync u_pin_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_level (i_pin_in),
    .o_level (pin_level)
  );

  // Address decode
  // A transfer runs setup, one wait cycle in which the answer is prepared,
  // then an access cycle with pready high. A write lands on that last edge,
  // so a read issued straight after it already sees the new value. An
  // unmapped address answers with pslverr and leaves both registers alone.
  // Only the exact word address matches; upper address bits must be zero.
  assign access   = psel && penable;
  assign hit_dir  = addr_hit(paddr, port_five_pkg::DIR_INDEX);
  assign hit_data = addr_hit(paddr, port_five_pkg::DATA_INDEX);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.ready  = 1'b0;
    st_next.slverr = 1'b0;
    st_next.rdata  = port_five_pkg::RDATA_NONE;

    // First access cycle: prepare answer, raise pready next cycle
    if (access && !st_reg.ready) begin
      st_next.ready = 1'b1;
      if (hit_dir) begin
        if (!pwrite) begin
          st_next.rdata = {port_five_pkg::RDATA_PAD, port_five_pkg::DIR_READ};  // see RL1
        end
      end else if (hit_data) begin
        if (!pwrite) begin
          st_next.rdata = {port_five_pkg::RDATA_PAD,
                           port_read(st_reg.dir, st_reg.data, pin_level)};
        end
      end else begin
        st_next.slverr = 1'b1;
      end
    end

    // Completing edge: write takes effect, held off in software standby
    if (access && st_reg.ready && pwrite && !i_sw_standby) begin  // see RL3
      if (hit_dir) begin
        st_next.dir = pwdata[7:0];                                 // see RL1
      end
      if (hit_data) begin
        st_next.data = pwdata[port_five_pkg::PIN_COUNT-1:0];       // see RL4 see RL8
      end
    end

    // Hardware standby reinitialises both registers
    if (i_hw_standby) begin
      st_next.dir  = port_five_pkg::DIR_RESET;                                // see RL2
      st_next.data = port_five_pkg::DATA_RESET[port_five_pkg::PIN_COUNT-1:0]; // see RL5
    end

    // Chip-select pins: driver follows direction bit
    // The data bits behind pins four to one are kept and read back, but
    // never reach a pin: a set direction bit hands the pin to its select.
    st_next.pin_oe[port_five_pkg::PIN_CS0:port_five_pkg::PIN_CS3] =
      st_reg.dir[port_five_pkg::PIN_CS0:port_five_pkg::PIN_CS3];  // see RL9 see RL10
    st_next.pin_out[port_five_pkg::PIN_CS0] = i_chip_select_zero_n;   // see RL9
    st_next.pin_out[port_five_pkg::PIN_CS1] = i_chip_select_one_n;
    st_next.pin_out[port_five_pkg::PIN_CS2] = i_chip_select_two_n;
    st_next.pin_out[port_five_pkg::PIN_CS3] = i_chip_select_three_n;

    // Pin zero: refresh strobe overrides the plain port function
    if (i_refresh_output_enable) begin
      st_next.pin_oe[port_five_pkg::PIN_GENERIC]  = 1'b1;                // see RL11
      st_next.pin_out[port_five_pkg::PIN_GENERIC] = i_refresh_strobe_n;
    end else begin
      st_next.pin_oe[port_five_pkg::PIN_GENERIC]  =
        st_reg.dir[port_five_pkg::PIN_GENERIC];                          // see RL10
      st_next.pin_out[port_five_pkg::PIN_GENERIC] =
        st_reg.data[port_five_pkg::PIN_GENERIC];                         // see RL9
    end

    // Interrupt requests follow pin levels whatever the pin function
    st_next.irq_n = pin_level[port_five_pkg::IRQ_COUNT-1:0];             // see RL12
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_reg         <= '0;
      st_reg.dir     <= port_five_pkg::DIR_RESET;                                // see RL2
      st_reg.data    <= port_five_pkg::DATA_RESET[port_five_pkg::PIN_COUNT-1:0]; // see RL5
      st_reg.irq_n   <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign prdata                = st_reg.rdata;
  assign pready                = st_reg.ready;
  assign pslverr               = st_reg.slverr;
  assign o_pin_out             = st_reg.pin_out;
  assign o_pin_oe              = st_reg.pin_oe;
  assign o_interrupt_request_n = st_reg.irq_n;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // All checks run on the one clock and stand down while reset is high.
  // Request-side checks look at the first access cycle, in which the
  // answer is prepared; write checks look at the completing edge.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  AST_DIR_READ_ONES: assert property ( // see RL1
    (access && !pready && !pwrite && hit_dir) |=> (prdata == 32'h000000ff) && pready
  ) else $error("direction read did not return all ones");

  // Standby loads the direction value; a cycle later pin four drives again
  AST_DIR_STANDBY_INIT: assert property ( // see RL2
    i_hw_standby |=> (st_reg.dir == port_five_pkg::DIR_RESET)
      ##1 (o_pin_oe[4:1] == port_five_pkg::DIR_RESET[4:1])
  ) else $error("hardware standby did not load direction value");

  AST_SW_STANDBY_HOLD: assert property ( // see RL3
    (i_sw_standby && !i_hw_standby) |=> $stable(st_reg.dir) && $stable(st_reg.data)
  ) else $error("software standby changed port registers");

  AST_DATA_WRITE: assert property ( // see RL4
    (access && pready && pwrite && hit_data && !i_sw_standby && !i_hw_standby)
      |=> st_reg.data == $past(pwdata[4:0])
  ) else $error("data register write lost");

  AST_DATA_STANDBY_INIT: assert property ( // see RL5
    i_hw_standby |=> st_reg.data == 5'h00
  ) else $error("hardware standby did not load data value");

  AST_PORT_READ_MIX: assert property ( // see RL6
    (access && !pready && !pwrite && hit_data) |=>
      prdata[4:0] == (($past(st_reg.dir[4:0]) & $past(st_reg.data))
                   | (~$past(st_reg.dir[4:0]) & $past(pin_level)))
  ) else $error("port read mixes data and pins wrongly");

  AST_RSVD_ONES: assert property ( // see RL8
    (access && !pready && !pwrite && hit_data) |=> prdata[7:5] == 3'h7
  ) else $error("reserved data bits not read as one");

  AST_CS_DRIVE: assert property ( // see RL9
    st_reg.dir[4] |=> o_pin_oe[4] && (o_pin_out[4] == $past(i_chip_select_zero_n))
  ) else $error("chip select zero not driven on pin four");

  AST_INPUT_OFF: assert property ( // see RL10
    (!st_reg.dir[1] && !st_reg.dir[2]) |=> !o_pin_oe[1] && !o_pin_oe[2]
  ) else $error("input pin driver left on");

  AST_REFRESH_PIN: assert property ( // see RL11
    i_refresh_output_enable |=> o_pin_oe[0] && (o_pin_out[0] == $past(i_refresh_strobe_n))
  ) else $error("refresh strobe not on pin zero");

  AST_IRQ_FOLLOW: assert property ( // see RL12
    ##1 o_interrupt_request_n == $past(pin_level[3:0])
  ) else $error("interrupt request does not follow pin");

  // ----------------------------------------------------------------------
  // Assertions on register writes and standby
  // ----------------------------------------------------------------------

  // Direction write lands on the completing edge unless a standby holds it
  AST_DIR_WRITE: assert property ( // see RL1
    (access && pready && pwrite && hit_dir && !i_sw_standby && !i_hw_standby)
      |=> st_reg.dir == $past(pwdata[7:0])
  ) else $error("direction register write lost");

  // Pin zero keeps driving its data bit while software standby is in force
  AST_SW_STANDBY_DRIVE: assert property ( // see RL3
    (i_sw_standby && !i_hw_standby && st_reg.dir[0] && !i_refresh_output_enable)
      |=> o_pin_oe[0] && (o_pin_out[0] == $past(st_reg.data[0]))
  ) else $error("output pin released in software standby");

  // An unmapped write changes neither register
  AST_UNMAPPED_KEEP: assert property ( // see RL4
    (access && pready && pwrite && !hit_dir && !hit_data && !i_hw_standby)
      |=> $stable(st_reg.dir) && $stable(st_reg.data)
  ) else $error("unmapped write changed a port register");

  // An unmapped access is answered with an error and no data
  AST_UNMAPPED_ERR: assert property ( // see RL4
    (access && !pready && !hit_dir && !hit_data)
      |=> pready && pslverr && (prdata == port_five_pkg::RDATA_NONE)
  ) else $error("unmapped access not refused");

  // Hardware standby wins over a write completing in the same cycle
  AST_DATA_STANDBY_WINS: assert property ( // see RL5
    (i_hw_standby && access && pready && pwrite && hit_data)
      |=> st_reg.data == port_five_pkg::DATA_RESET[port_five_pkg::PIN_COUNT-1:0]
  ) else $error("write beat hardware standby");

  // ----------------------------------------------------------------------
  // Assertions on the port read and pin functions
  // ----------------------------------------------------------------------

  // All pins outputs: the read returns the stored data bits
  AST_PORT_READ_OUTPUT: assert property ( // see RL6
    (access && !pready && !pwrite && hit_data && st_reg.dir[4:0] == 5'h1f)
      |=> prdata[4:0] == $past(st_reg.data)
  ) else $error("output pin read did not return stored data");

  // All pins inputs: the read returns the synchronised pin levels
  AST_PORT_READ_INPUT: assert property ( // see RL7
    (access && !pready && !pwrite && hit_data && st_reg.dir[4:0] == 5'h00)
      |=> prdata[4:0] == $past(pin_level)
  ) else $error("input pin read did not return pin level");

  // Pins three to one carry chip selects one to three when set as outputs
  AST_CS_UPPER: assert property ( // see RL9
    (st_reg.dir[3:1] == 3'h7) |=> (o_pin_oe[3:1] == 3'h7) && (o_pin_out[3:1] ==
      $past({i_chip_select_one_n, i_chip_select_two_n, i_chip_select_three_n}))
  ) else $error("chip selects one to three not on pins three to one");

  // Pin zero is a plain output of its data bit without refresh
  AST_PIN_ZERO_OUT: assert property ( // see RL9
    (!i_refresh_output_enable && st_reg.dir[0])
      |=> o_pin_oe[0] && (o_pin_out[0] == $past(st_reg.data[0]))
  ) else $error("pin zero does not drive its data bit");

  // Cleared direction bits release pins four, three and zero
  AST_INPUT_OFF_REST: assert property ( // see RL10
    (!st_reg.dir[4] && !st_reg.dir[3] && !st_reg.dir[0] && !i_refresh_output_enable)
      |=> !o_pin_oe[4] && !o_pin_oe[3] && !o_pin_oe[0]
  ) else $error("pin driver left on for an input");

  // Refresh strobe takes pin zero even when its direction bit is clear
  AST_REFRESH_OVERRIDE: assert property ( // see RL11
    (i_refresh_output_enable && !st_reg.dir[0])
      |=> o_pin_oe[0] && (o_pin_out[0] == $past(i_refresh_strobe_n))
  ) else $error("refresh strobe lost to an input direction bit");

  COV_DATA_WRITE: cover property (access && pready && pwrite && hit_data);
  COV_DIR_READ: cover property (access && pready && !pwrite && hit_dir);
  COV_REFRESH: cover property (i_refresh_output_enable ##1 o_pin_oe[0]);
  COV_UNMAPPED: cover property (pready && pslverr);
  COV_SW_STANDBY_WRITE: cover property (access && pready && pwrite && i_sw_standby);

endmodule // port_five

`default_nettype wire

// ### logic/port_five_pkg.sv
// Constants shared by the five-bit select-mux port and its pin synchroniser
package port_five_pkg;

  // ----------------------------------------------------------------------
  // Pin layout
  // ----------------------------------------------------------------------
  localparam int unsigned PIN_COUNT   = 5;
  localparam int unsigned IRQ_COUNT   = 4;
  localparam int unsigned PIN_GENERIC = 0;  // Plain output or refresh strobe
  localparam int unsigned PIN_CS3     = 1;  // Pin carrying chip select three
  localparam int unsigned PIN_CS2     = 2;  // Pin carrying chip select two
  localparam int unsigned PIN_CS1     = 3;  // Pin carrying chip select one
  localparam int unsigned PIN_CS0     = 4;  // Pin carrying chip select zero

  // ----------------------------------------------------------------------
  // Register map (register index, byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] DIR_INDEX  = 16'hffcd;
  localparam logic [15:0] DATA_INDEX = 16'hffcf;
  localparam logic [13:0] ADDR_PAD   = 14'h0000;
  localparam logic [1:0]  ADDR_LANE  = 2'h0;

  // ----------------------------------------------------------------------
  // Reset values and fixed read patterns
  // ----------------------------------------------------------------------
  localparam logic [7:0]  DIR_RESET   = 8'hf0;
  localparam logic [7:0]  DATA_RESET  = 8'he0;
  localparam logic [7:0]  DIR_READ    = 8'hff;
  localparam logic [2:0]  DATA_RSVD   = 3'h7;
  localparam logic [23:0] RDATA_PAD   = 24'h000000;
  localparam logic [31:0] RDATA_NONE  = 32'h00000000;

endpackage : port_five_pkg

// ### logic/pin_sync.sv
// Two-stage synchroniser for the port pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input  wire logic                               i_clock,
  input  wire logic                               i_reset,
  input  wire logic [port_five_pkg::PIN_COUNT-1:0] i_level,
  output logic      [port_five_pkg::PIN_COUNT-1:0] o_level
);

  typedef struct packed {
    logic [port_five_pkg::PIN_COUNT-1:0] stage1;
    logic [port_five_pkg::PIN_COUNT-1:0] stage2;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // ----------------------------------------------------------------------
  // Next state: first stage feeds only the second
  // ----------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.stage1 = i_level;
    st_next.stage2 = st_reg.stage1;
  end

  // State register; resets to ones so active-low requests stay idle after reset
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.stage2;

endmodule // pin_sync

`default_nettype wire

// ### verif/pin_partner.sv
// Pin-side model of the external parties on the five port pins
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
  input  wire logic [port_five_pkg::PIN_COUNT-1:0] i_pin_out,
  input  wire logic [port_five_pkg::PIN_COUNT-1:0] i_pin_oe,
  input  wire logic [port_five_pkg::PIN_COUNT-1:0] i_drive_value,
  input  wire logic                                i_drive_enable,
  input  wire logic                                i_clock,
  output logic      [port_five_pkg::PIN_COUNT-1:0] o_level
);
  logic [port_five_pkg::PIN_COUNT-1:0] float_reg;

  // Undriven lines toggle each cycle so a stale level never reads as real
  always_ff @(posedge i_clock) begin
    float_reg <= ~o_level;
  end

  // Wire level: device driver first, then the far side, else floating
  always_comb begin
    for (int i = 0; i < port_five_pkg::PIN_COUNT; i++) begin
      o_level[i] = i_pin_oe[i] ? i_pin_out[i] :
                   (i_drive_enable ? i_drive_value[i] : float_reg[i]);
    end
  end
endmodule // pin_partner
`default_nettype wire

// ### verif/tb_port_five.sv
// Self-checking bench for the five-bit select-mux port
`timescale 1ns/1ps
`default_nettype none

module tb_port_five;
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
    logic [4:0] drv;
    logic [3:0] cs;
    logic [7:0] rd;
    logic [4:0] oe;
    logic [4:0] out;
    logic [3:0] irq;
  } row_t;

  localparam logic [31:0] DIR_A  = {port_five_pkg::ADDR_PAD, port_five_pkg::DIR_INDEX,
                                    port_five_pkg::ADDR_LANE};
  localparam logic [31:0] DATA_A = {port_five_pkg::ADDR_PAD, port_five_pkg::DATA_INDEX,
                                    port_five_pkg::ADDR_LANE};
  localparam logic [31:0] BAD_A  = 32'h0003ff38;

  logic        i_clock, i_reset, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic        i_hw_standby, i_sw_standby, i_refresh_strobe_n, i_refresh_output_enable;
  logic        cs0_n, cs1_n, cs2_n, cs3_n, drive_en;
  logic [4:0]  pin_level, pin_out, pin_oe, drv;
  logic [3:0]  irq_n;
  int          err_count, checked;
  row_t        rows [4];

  port_five port_five_inst (.i_clock(i_clock), .i_reset(i_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_hw_standby(i_hw_standby),
    .i_sw_standby(i_sw_standby), .i_chip_select_zero_n(cs0_n), .i_chip_select_one_n(cs1_n),
    .i_chip_select_two_n(cs2_n), .i_chip_select_three_n(cs3_n),
    .i_refresh_strobe_n(i_refresh_strobe_n), .i_refresh_output_enable(i_refresh_output_enable),
    .i_pin_in(pin_level), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_interrupt_request_n(irq_n));

  pin_partner pin_partner_inst (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_drive_value(drv),
    .i_drive_enable(drive_en), .i_clock(i_clock), .o_level(pin_level));

  // ----------------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // One APB transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge i_clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, addr, wd, rd, err);
  endtask

  task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr, 32'h00000000, rd, err);
    chk(name, exp, rd);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_count = 0;
    checked = 0;
    rows[0] = '{8'h01, 8'h1e, 5'h0a, 4'hf, 8'hea, 5'h01, 5'h00, 4'ha};
    rows[1] = '{8'h1f, 8'h01, 5'h00, 4'h5, 8'he1, 5'h1f, 5'h15, 4'h5};
    rows[2] = '{8'h00, 8'h1f, 5'h13, 4'hf, 8'hf3, 5'h00, 5'h00, 4'h3};
    rows[3] = '{8'h1e, 8'h00, 5'h01, 4'ha, 8'he1, 5'h1e, 5'h0a, 4'hb};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {i_hw_standby, i_sw_standby, i_refresh_output_enable} = '0;
    {i_refresh_strobe_n, cs3_n, cs2_n, cs1_n, cs0_n} = 5'h1f;
    drive_en = 1'b1;
    drv = 5'h00;
    i_reset = 1'b1;
    settle(5);
    i_reset <= 1'b0;
    drv     <= 5'h0a;
    settle(6);
    chk("oe after reset", 32'h10, {27'h0, pin_oe});
    rd_chk("direction read", DIR_A, 32'h000000ff, 1'b0);
    rd_chk("data after reset", DATA_A, 32'h000000ea, 1'b0);
    for (int i = 0; i < 4; i++) begin
      drv <= rows[i].drv;
      {cs3_n, cs2_n, cs1_n, cs0_n} <= rows[i].cs;
      wr(DIR_A, {24'h0, rows[i].dir});
      wr(DATA_A, {24'h0, rows[i].data});
      settle(6);
      chk("oe", {27'h0, rows[i].oe}, {27'h0, pin_oe});
      chk("out", {27'h0, rows[i].out}, {27'h0, pin_out & pin_oe});
      chk("irq", {28'h0, rows[i].irq}, {28'h0, irq_n});
      rd_chk("port read", DATA_A, {24'h0, rows[i].rd}, 1'b0);
    end
    // Refresh strobe takes pin zero over an input direction bit
    i_refresh_output_enable <= 1'b1;
    i_refresh_strobe_n      <= 1'b0;
    settle(3);
    chk("refresh oe", 32'h1, {31'h0, pin_oe[0]});
    chk("refresh low", 32'h0, {31'h0, pin_out[0]});
    i_refresh_strobe_n <= 1'b1;
    settle(3);
    chk("refresh high", 32'h1, {31'h0, pin_out[0]});
    i_refresh_output_enable <= 1'b0;
    settle(3);
    chk("refresh off", 32'h0, {31'h0, pin_oe[0]});
    // Software standby keeps both registers and the drivers
    wr(DIR_A, 32'h0000001f);
    wr(DATA_A, 32'hffffff1f);
    i_sw_standby <= 1'b1;
    wr(DATA_A, 32'h00000000);
    wr(DIR_A, 32'h00000000);
    settle(4);
    chk("standby oe", 32'h1f, {27'h0, pin_oe});
    rd_chk("standby data", DATA_A, 32'h000000ff, 1'b0);
    i_sw_standby <= 1'b0;
    // Unmapped place refuses and changes nothing
    wr(BAD_A, 32'h00000000);
    rd_chk("unmapped", BAD_A, 32'h00000000, 1'b1);
    rd_chk("data kept", DATA_A, 32'h000000ff, 1'b0);
    // Hardware standby reloads both registers
    drv <= 5'h06;
    i_hw_standby <= 1'b1;
    settle(2);
    i_hw_standby <= 1'b0;
    settle(6);
    chk("hw standby oe", 32'h10, {27'h0, pin_oe});
    rd_chk("hw standby data", DATA_A, 32'h000000e6, 1'b0);
    // Reset in mid-run: registers reload, requests stay idle meanwhile
    wr(DIR_A, 32'h0000000f);
    i_reset <= 1'b1;
    settle(2);
    i_reset <= 1'b0;
    settle(1);
    chk("oe in reset", 32'h0, {27'h0, pin_oe});
    settle(1);
    chk("oe after mid reset", 32'h10, {27'h0, pin_oe});
    chk("irq after mid reset", 32'hf, {28'h0, irq_n});
    rd_chk("data after mid reset", DATA_A, 32'h000000e6, 1'b0);
    tally_and_finish();
  end
endmodule // tb_port_five
`default_nettype wire
